// ==== rtl/host_port.sv ====
/*
 host-side pin logic of an octal line interface: serial and parallel register access to a
 byte bank, cycle ready/acknowledge, open-drain interrupt, hardware-mode pin decoding.
 assumes straps are static after reset, all pins are asynchronous to core_clk_i, and the
 sclk period is many core clocks long; two-way pins are resolved outside from the enables.
*/
// Chosen here: the Avalon-MM slave port and the placing of the registers.
// Summary of operation
// (R01) a serial write never enables the serial output pin.
// (R02) a serial read keeps the output pin off during its command/address byte.
// (R03) serial output bits launch on sclk rise with edge select low, on its fall when high.
// (R04) ready is low while a host cycle is unfinished and high once done; the host waits.
// (R05) in strobe style the active-low acknowledge goes low once read data or a write is done.
// (R06) in hardware mode a high termination-off pin switches receive termination off.
// (R07) the open-drain interrupt pulls low while any enabled source holds an event.
// (R08) with nothing pending it drives high or floats as programmed, floating after reset.
// (R09) a software reset disables every interrupt source until software enables it again.
// (R10) in non-multiplexed parallel mode the eight data pins are a two-way data bus.
// (R11) in multiplexed mode the pins carry address and data, the top two bits never address.
// (R12) in serial mode bit-order select low sends lsb first, high sends msb first.
// (R13) in hardware mode each loopback pin low selects remote, mid none, high analog loopback.
// (R14) the host presents serial input so it is sampled on each sclk rising edge.
// (R15) the host holds chip select low throughout every access.
// (R16) each three-level pin becomes a two-bit code registered before it selects loopback.
`timescale 1ns/10ps
`default_nettype none
module host_port #(
	parameter logic [3:0] ACK_CYCLES = 4'h2,
	parameter int ADDR_W = 6
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// avalon-mm slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// straps and events, core clock domain
	input wire logic [1:0] host_mode_i,
	input wire logic strobe_style_i,
	input wire logic [7:0] irq_event_i,
	// host control pins
	input wire logic serial_clk_pin_i,
	input wire logic serial_in_pin_i,
	input wire logic chip_select_n_i,
	input wire logic rd_rw_pin_i,
	input wire logic wr_ds_pin_i,
	input wire logic ale_pin_i,
	input wire logic output_edge_select_i,
	input wire logic [5:0] addr_pin_i,
	// data bus pins
	input wire logic [7:0] data_pin_i,
	output logic [7:0] data_pin_o,
	output logic data_pin_oe_o,
	// shared serial out / ready / ack / termination-off pin
	input wire logic serial_out_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	// open-drain interrupt
	output logic irq_out_n_o,
	output logic irq_out_n_oe_o,
	// hardware mode: three-level pin comparators and decoded controls
	input wire logic [7:0] loopback_select_hi_i,
	input wire logic [7:0] loopback_select_lo_i,
	output logic rx_termination_off_o,
	output logic [15:0] loopback_mode_o
);
	typedef enum logic [1:0] {PAR_IDLE, PAR_BUSY, PAR_DONE} par_state_e;

	logic [host_port_pkg::PIN_W-1:0] pins, s1_q, s2_q, s3_q, filt_q, filt_d;
	logic [7:0] mem_q [2**ADDR_W];
	logic mem_we;
	logic [ADDR_W-1:0] mem_wa;
	logic [7:0] mem_wd;
	logic serial_mode, par_mode, hw_mode, cs_act, msb_first;
	logic sclk_rise, sclk_fall, launch;
	logic [4:0] scnt_q, scnt_d;
	logic [3:0] ocnt_q, ocnt_d;
	logic [7:0] ish_q, ish_d, osh_q, osh_d;
	logic [ADDR_W-1:0] saddr_q, saddr_d;
	logic srd_q, srd_d, swr_q, swr_d, sdo_q, sdo_d;
	par_state_e pst_q, pst_d;
	logic [3:0] pcnt_q, pcnt_d;
	logic [ADDR_W-1:0] paddr_q, paddr_d, lat_q, lat_d;
	logic prd_q, prd_d, rd_req, wr_req;
	logic [7:0] prdata_q, prdata_d;
	logic drv_hi_q, drv_hi_d, irq_n_q, irq_n_d, irq_oe_q, irq_oe_d, pend;
	logic [7:0] en_q, en_d, stat_q, stat_d;
	logic ack_q, ack_d, take_wr, swrst;
	logic [31:0] rdata_q, rdata_d;
	logic term_q, term_d;
	logic [15:0] lb_q, lb_d;

	assign pins = {addr_pin_i, loopback_select_lo_i, loopback_select_hi_i, data_pin_i,
		serial_out_pin_i, output_edge_select_i, ale_pin_i, wr_ds_pin_i, rd_rw_pin_i,
		chip_select_n_i, serial_in_pin_i, serial_clk_pin_i};

	// a pin level is accepted only once stages two and three agree
	always_comb begin
		filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			s1_q <= host_port_pkg::PIN_RST;
			s2_q <= host_port_pkg::PIN_RST;
			s3_q <= host_port_pkg::PIN_RST;
			filt_q <= host_port_pkg::PIN_RST;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	assign serial_mode = (host_mode_i == host_port_pkg::MODE_SERIAL);
	assign par_mode = (host_mode_i == host_port_pkg::MODE_PAR_NONMUX) ||
		(host_mode_i == host_port_pkg::MODE_PAR_MUX);
	assign hw_mode = (host_mode_i == host_port_pkg::MODE_HW);
	assign cs_act = !filt_q[host_port_pkg::P_CS]; // R15
	assign msb_first = filt_q[host_port_pkg::P_DATA+7]; // R12
	assign sclk_rise = !filt_q[host_port_pkg::P_SCLK] && filt_d[host_port_pkg::P_SCLK];
	assign sclk_fall = filt_q[host_port_pkg::P_SCLK] && !filt_d[host_port_pkg::P_SCLK];
	assign launch = filt_q[host_port_pkg::P_EDGE] ? sclk_fall : sclk_rise; // R03

	// serial engine: rw bit and address first, then one data byte
	always_comb begin
		logic [7:0] byte_n;
		byte_n = msb_first ? {ish_q[6:0], filt_q[host_port_pkg::P_SDI]} :
			{filt_q[host_port_pkg::P_SDI], ish_q[7:1]}; // R12 R14
		scnt_d = scnt_q;
		ocnt_d = ocnt_q;
		ish_d = ish_q;
		osh_d = osh_q;
		saddr_d = saddr_q;
		srd_d = srd_q;
		swr_d = swr_q;
		sdo_d = sdo_q;
		if (!(serial_mode && cs_act)) begin
			scnt_d = 5'h00;
			ocnt_d = 4'h0;
			srd_d = 1'b0;
			swr_d = 1'b0;
		end else begin
			if (sclk_rise && scnt_q < host_port_pkg::FRAME_BITS) begin // R14
				ish_d = byte_n;
				scnt_d = scnt_q + 5'h01;
				if (scnt_q == host_port_pkg::CMD_BITS - 5'h01) begin
					srd_d = byte_n[7];
					swr_d = !byte_n[7];
					saddr_d = byte_n[ADDR_W-1:0];
					osh_d = mem_q[byte_n[ADDR_W-1:0]];
				end
			end
			if (srd_q && launch && ocnt_q < host_port_pkg::DATA_BITS) begin // R03
				sdo_d = msb_first ? osh_q[7] : osh_q[0];
				osh_d = msb_first ? {osh_q[6:0], 1'b0} : {1'b0, osh_q[7:1]};
				ocnt_d = ocnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			scnt_q <= 5'h00;
			ocnt_q <= 4'h0;
			ish_q <= 8'h00;
			osh_q <= 8'h00;
			saddr_q <= '0;
			srd_q <= 1'b0;
			swr_q <= 1'b0;
			sdo_q <= 1'b0;
		end else begin
			scnt_q <= scnt_d;
			ocnt_q <= ocnt_d;
			ish_q <= ish_d;
			osh_q <= osh_d;
			saddr_q <= saddr_d;
			srd_q <= srd_d;
			swr_q <= swr_d;
			sdo_q <= sdo_d;
		end
	end

	// parallel engine; strobe style uses data strobe plus read/write level
	always_comb begin
		if (strobe_style_i) begin
			rd_req = !filt_q[host_port_pkg::P_WRDS] && filt_q[host_port_pkg::P_RDRW];
			wr_req = !filt_q[host_port_pkg::P_WRDS] && !filt_q[host_port_pkg::P_RDRW];
		end else begin
			rd_req = !filt_q[host_port_pkg::P_RDRW];
			wr_req = !filt_q[host_port_pkg::P_WRDS];
		end
	end

	always_comb begin
		pst_d = pst_q;
		pcnt_d = pcnt_q;
		paddr_d = paddr_q;
		prd_d = prd_q;
		prdata_d = prdata_q;
		lat_d = lat_q;
		// address half of the muxed bus, top two bits never address
		if (filt_q[host_port_pkg::P_ALE] && !filt_d[host_port_pkg::P_ALE]) begin
			lat_d = filt_q[host_port_pkg::P_DATA +: ADDR_W]; // R11
		end
		case (pst_q)
			PAR_IDLE: begin
				if (par_mode && cs_act && (rd_req || wr_req)) begin
					pst_d = PAR_BUSY;
					pcnt_d = 4'h0;
					prd_d = rd_req;
					paddr_d = (host_mode_i == host_port_pkg::MODE_PAR_MUX) ? lat_q :
						filt_q[host_port_pkg::P_ADDR +: ADDR_W]; // R11
				end
			end
			PAR_BUSY: begin
				pcnt_d = pcnt_q + 4'h1;
				if (!(cs_act && (rd_req || wr_req))) begin
					pst_d = PAR_IDLE;
				end else if (pcnt_q == ACK_CYCLES - 4'h1) begin
					pst_d = PAR_DONE;
					prdata_d = mem_q[paddr_q];
				end
			end
			PAR_DONE: begin
				if (!(cs_act && (rd_req || wr_req))) begin
					pst_d = PAR_IDLE;
				end
			end
			default: pst_d = PAR_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pst_q <= PAR_IDLE;
			pcnt_q <= 4'h0;
			paddr_q <= '0;
			prd_q <= 1'b0;
			prdata_q <= 8'h00;
			lat_q <= '0;
		end else begin
			pst_q <= pst_d;
			pcnt_q <= pcnt_d;
			paddr_q <= paddr_d;
			prd_q <= prd_d;
			prdata_q <= prdata_d;
			lat_q <= lat_d;
		end
	end

	// byte bank; modes are exclusive so only one engine writes at a time
	always_comb begin
		mem_we = 1'b0;
		mem_wa = saddr_q;
		mem_wd = ish_d;
		if (serial_mode && swr_q && sclk_rise && scnt_q == host_port_pkg::FRAME_BITS - 5'h01) begin
			mem_we = 1'b1;
		end else if (pst_q == PAR_BUSY && pst_d == PAR_DONE && !prd_q) begin
			mem_we = 1'b1;
			mem_wa = paddr_q;
			mem_wd = filt_q[host_port_pkg::P_DATA +: 8]; // R10
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (mem_we) begin
			mem_q[mem_wa] <= mem_wd;
		end
	end

	// shared pin: sdo in serial, ready or ack in parallel, input in hardware mode
	always_comb begin
		serial_out_pin_o = 1'b1;
		serial_out_pin_oe_o = 1'b0;
		if (serial_mode) begin
			serial_out_pin_o = sdo_q;
			serial_out_pin_oe_o = cs_act && srd_q; // R01 R02
		end else if (par_mode) begin
			serial_out_pin_oe_o = cs_act;
			if (strobe_style_i) begin
				serial_out_pin_o = (pst_q != PAR_DONE); // R05
			end else begin
				serial_out_pin_o = (pst_q != PAR_BUSY); // R04
			end
		end
	end

	assign data_pin_o = prdata_q;
	assign data_pin_oe_o = par_mode && cs_act && prd_q && pst_q == PAR_DONE; // R10

	// hardware mode decode, registered before use
	always_comb begin
		term_d = hw_mode && filt_q[host_port_pkg::P_TERM]; // R06
		for (int i = 0; i < 8; i++) begin
			if (!hw_mode) begin
				lb_d[2*i +: 2] = host_port_pkg::LOOP_NONE;
			end else if (filt_q[host_port_pkg::P_LPLO + i]) begin
				lb_d[2*i +: 2] = host_port_pkg::LOOP_REMOTE; // R13 R16
			end else if (filt_q[host_port_pkg::P_LPHI + i]) begin
				lb_d[2*i +: 2] = host_port_pkg::LOOP_ANALOG; // R13 R16
			end else begin
				lb_d[2*i +: 2] = host_port_pkg::LOOP_NONE;
			end
		end
	end

	// avalon slave: one wait cycle, then the answer
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
	assign take_wr = avs_write_i && ack_q && avs_byteenable_i[0];
	assign swrst = take_wr && avs_address_i == host_port_pkg::CTRL_OFS &&
		avs_writedata_i[host_port_pkg::CTRL_SWRST_BIT];

	always_comb begin
		ack_d = (avs_read_i || avs_write_i) && !ack_q;
		rdata_d = rdata_q;
		drv_hi_d = drv_hi_q;
		en_d = en_q;
		stat_d = stat_q;
		if (avs_read_i && !ack_q) begin
			rdata_d = 32'h0000_0000;
			case (avs_address_i)
				host_port_pkg::CTRL_OFS: rdata_d[host_port_pkg::CTRL_DRV_HI_BIT] = drv_hi_q;
				host_port_pkg::IRQ_EN_OFS: rdata_d[7:0] = en_q;
				host_port_pkg::IRQ_STAT_OFS: rdata_d[7:0] = stat_q;
				host_port_pkg::STATUS_OFS: begin
					rdata_d[15:0] = lb_q;
					rdata_d[host_port_pkg::STAT_TERM_BIT] = term_q;
					rdata_d[host_port_pkg::STAT_MODE_LSB +: 2] = host_mode_i;
					rdata_d[host_port_pkg::STAT_IRQ_BIT] = pend;
				end
				default: rdata_d = 32'h0000_0000;
			endcase
		end
		if (take_wr && avs_address_i == host_port_pkg::CTRL_OFS) begin
			drv_hi_d = avs_writedata_i[host_port_pkg::CTRL_DRV_HI_BIT]; // R08
		end
		if (take_wr && avs_address_i == host_port_pkg::IRQ_EN_OFS) begin
			en_d = avs_writedata_i[7:0];
		end
		if (swrst) begin
			en_d = host_port_pkg::IRQ_EN_RST; // R09
		end
		if (take_wr && avs_address_i == host_port_pkg::IRQ_STAT_OFS) begin
			stat_d = stat_q & ~avs_writedata_i[7:0];
		end
		stat_d = stat_d | irq_event_i; // set wins over clear
	end

	assign pend = |(stat_q & en_q);
	assign irq_n_d = !pend; // R07
	assign irq_oe_d = pend || drv_hi_q; // R07 R08

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			drv_hi_q <= host_port_pkg::CTRL_DRV_HI_RST;
			en_q <= host_port_pkg::IRQ_EN_RST;
			stat_q <= host_port_pkg::IRQ_STAT_RST;
			irq_n_q <= 1'b1;
			irq_oe_q <= 1'b0;
			term_q <= 1'b0;
			lb_q <= 16'h0000;
		end else begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			drv_hi_q <= drv_hi_d;
			en_q <= en_d;
			stat_q <= stat_d;
			irq_n_q <= irq_n_d;
			irq_oe_q <= irq_oe_d;
			term_q <= term_d;
			lb_q <= lb_d;
		end
	end

	assign avs_readdata_o = rdata_q;
	assign irq_out_n_o = irq_n_q;
	assign irq_out_n_oe_o = irq_oe_q;
	assign rx_termination_off_o = term_q;
	assign loopback_mode_o = lb_q;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	sdo_write_off_a: assert property (serial_mode && swr_q |-> !serial_out_pin_oe_o) // R01
		else $error("serial out driven during a write");
	sdo_cmd_off_a: assert property ( // R02
		serial_mode && scnt_q < host_port_pkg::CMD_BITS |-> !serial_out_pin_oe_o)
		else $error("serial out driven during command bits");
	sdo_launch_edge_a: assert property ($changed(sdo_q) |-> $past(launch)) // R03
		else $error("serial out changed off the launch edge");
	ready_busy_low_a: assert property ( // R04
		par_mode && !strobe_style_i && cs_act && pst_q == PAR_BUSY
		|-> serial_out_pin_oe_o && !serial_out_pin_o)
		else $error("ready not low while busy");
	ack_done_low_a: assert property ( // R05
		par_mode && strobe_style_i && pst_q == PAR_BUSY ##1 pst_q == PAR_DONE && cs_act
		|-> !serial_out_pin_o && serial_out_pin_oe_o)
		else $error("ack not low at completion");
	term_off_a: assert property (hw_mode && filt_q[host_port_pkg::P_TERM] |=> term_q) // R06
		else $error("termination not switched off");
	irq_pull_low_a: assert property (pend |=> !irq_out_n_o && irq_out_n_oe_o) // R07
		else $error("interrupt not pulled low");
	irq_float_a: assert property (!pend && !drv_hi_q |=> !irq_out_n_oe_o) // R08
		else $error("interrupt driven with nothing pending");
	swrst_disable_a: assert property (swrst |=> en_q == 8'h00 ##1 !pend) // R09
		else $error("sources still enabled after software reset");
	data_drive_a: assert property (data_pin_oe_o |-> prd_q && pst_q == PAR_DONE) // R10
		else $error("data bus driven outside a read");
	mux_latch_a: assert property ( // R11
		filt_q[host_port_pkg::P_ALE] && !filt_d[host_port_pkg::P_ALE]
		|=> lat_q == $past(filt_q[host_port_pkg::P_DATA +: ADDR_W]))
		else $error("muxed address not latched");
	loop_remote_a: assert property ( // R13 R16
		hw_mode && filt_q[host_port_pkg::P_LPLO] |=> lb_q[1:0] == host_port_pkg::LOOP_REMOTE)
		else $error("remote loopback not selected");
endmodule
`default_nettype wire

// ==== rtl/host_port_pkg.sv ====
/*
 holds the register map, field positions, mode codes and pin-vector layout of the host port.
 assumes a single core clock; all users reference names as host_port_pkg::name.
*/
package host_port_pkg;
	// register byte offsets on the avalon slave
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] IRQ_EN_OFS = 4'h4;
	localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
	localparam logic [3:0] STATUS_OFS = 4'hC;
	// field positions
	localparam int CTRL_DRV_HI_BIT = 0;
	localparam int CTRL_SWRST_BIT = 1;
	localparam int STAT_TERM_BIT = 16;
	localparam int STAT_MODE_LSB = 17;
	localparam int STAT_IRQ_BIT = 19;
	// reset values
	localparam logic CTRL_DRV_HI_RST = 1'b0;
	localparam logic [7:0] IRQ_EN_RST = 8'h00;
	localparam logic [7:0] IRQ_STAT_RST = 8'h00;
	// host mode straps
	localparam logic [1:0] MODE_SERIAL = 2'h0;
	localparam logic [1:0] MODE_PAR_NONMUX = 2'h1;
	localparam logic [1:0] MODE_PAR_MUX = 2'h2;
	localparam logic [1:0] MODE_HW = 2'h3;
	// loopback codes per channel
	localparam logic [1:0] LOOP_NONE = 2'h0;
	localparam logic [1:0] LOOP_REMOTE = 2'h1;
	localparam logic [1:0] LOOP_ANALOG = 2'h2;
	// serial frame: command byte then data byte
	localparam logic [4:0] CMD_BITS = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [3:0] DATA_BITS = 4'h8;
	// synchronised pin vector layout
	localparam int P_SCLK = 0;
	localparam int P_SDI = 1;
	localparam int P_CS = 2;
	localparam int P_RDRW = 3;
	localparam int P_WRDS = 4;
	localparam int P_ALE = 5;
	localparam int P_EDGE = 6;
	localparam int P_TERM = 7;
	localparam int P_DATA = 8;
	localparam int P_LPHI = 16;
	localparam int P_LPLO = 24;
	localparam int P_ADDR = 32;
	localparam int PIN_W = 38;
	// idle pin levels: chip select, strobes and ale high
	localparam logic [37:0] PIN_RST = 38'h0000_0003C;
endpackage

// ==== bench/host_cpu_model.sv ====
/*
 behavioural host processor driving the host port pins with serial frames and parallel cycles.
 assumes the bench resolves the two-way pins and feeds their wire levels back in.
*/
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
	// host-driven control pins
	output var logic sclk_o = 1'b0,
	output var logic sdi_o = 1'b0,
	output var logic cs_n_o = 1'b1,
	output var logic rd_rw_o = 1'b1,
	output var logic wr_ds_o = 1'b1,
	output var logic ale_o = 1'b1,
	output var logic edge_o = 1'b0,
	output var logic [5:0] addr_o = 6'h00,
	// host side of the data bus
	output var logic [7:0] data_o = 8'h00,
	output var logic data_oe_o = 1'b1,
	// wire levels seen by the host
	input wire logic sdo_wire_i,
	input wire logic sdo_oe_i,
	input wire logic [7:0] data_wire_i
);
	function automatic logic [7:0] shin(logic [7:0] r, logic msb, logic b);
		return msb ? {r[6:0], b} : {b, r[7:1]};
	endfunction

	// sclk only toggles inside a frame; the 7 ns offset keeps its edges off the core clock edges
	task automatic ser_xfer(input logic rd, input logic msb, input logic e, input logic [5:0] a,
		input logic [7:0] wd, output logic [7:0] rx, output logic bad);
		logic [7:0] cmd;
		logic [15:0] fr;
		cmd = {rd, 1'b0, a};
		if (msb) fr = {cmd, wd};
		else fr = {<<{wd, cmd}};
		rx = 8'h00;
		bad = 1'b0;
		#7;
		data_o = {msb, 7'h00};
		edge_o = e;
		cs_n_o = 1'b0;
		#200;
		for (int n = 1; n <= 17; n++) begin
			if (n <= 16) sdi_o = fr[16 - n];
			#160;
			if ((!rd || n <= 8) && sdo_oe_i !== 1'b0) bad = 1'b1;
			if (!e && n >= 10) rx = shin(rx, msb, sdo_wire_i);
			if (n <= 16) sclk_o = 1'b1;
			#160;
			if (e && n >= 9 && n <= 16) rx = shin(rx, msb, sdo_wire_i);
			if (n <= 16) sclk_o = 1'b0;
		end
		cs_n_o = 1'b1;
		#400;
	endtask

	task automatic wait_sdo(input logic v, inout logic ok);
		int k;
		k = 0;
		while (sdo_wire_i !== v && k < 60) begin
			#40;
			k++;
		end
		if (sdo_wire_i !== v) ok = 1'b0;
	endtask

	task automatic par_cycle(input logic rd, input logic style, input logic mux,
		input logic [5:0] a, input logic [7:0] wd, output logic [7:0] rdat, output logic ok);
		ok = 1'b1;
		#7;
		cs_n_o = 1'b0;
		if (mux) begin
			data_o = {2'b11, a};
			addr_o = 6'h00;
			#80;
			ale_o = 1'b0;
			#80;
		end else begin
			addr_o = a;
		end
		data_o = wd;
		data_oe_o = !rd;
		#200;
		rd_rw_o = style ? rd : !rd;
		wr_ds_o = style ? 1'b0 : rd;
		if (!style) wait_sdo(1'b0, ok);
		wait_sdo(style ? 1'b0 : 1'b1, ok);
		rdat = data_wire_i;
		#40;
		rd_rw_o = 1'b1;
		wr_ds_o = 1'b1;
		#80;
		cs_n_o = 1'b1;
		ale_o = 1'b1;
		data_oe_o = 1'b1;
		#160;
	endtask
endmodule
`default_nettype wire

// ==== bench/host_port_tb.sv ====
/*
 self-checking bench for the host port: registers over avalon, interrupt pin, serial and
 parallel host access through a host model, hardware-mode pin decoding.
 assumes the design and package under rtl/ and the host model under bench/.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module host_port_tb;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [1:0] host_mode_i = host_port_pkg::MODE_SERIAL;
	logic strobe_style_i = 1'b0;
	logic [7:0] irq_event_i = 8'h00;
	logic [7:0] lp_hi = 8'h00;
	logic [7:0] lp_lo = 8'h00;
	logic term_off = 1'b0;
	logic [7:0] data_pin_o, host_d;
	logic data_pin_oe_o, serial_out_pin_o, serial_out_pin_oe_o, irq_out_n_o, irq_out_n_oe_o;
	logic rx_termination_off_o, sclk, serial_in_pin, cs_n, rd_rw, wr_ds, ale, edge_sel, host_oe;
	logic [15:0] loopback_mode_o;
	logic [5:0] addr;
	wire logic sdo_wire, irq_wire;
	wire logic [7:0] data_wire;
	int fail_count = 0;
	int n_tests = 0;
	logic [31:0] rd;
	logic [7:0] rx;
	logic bad, ok;

	always #20 core_clk_i = ~core_clk_i;

	// released pins show the inverse of the last driven value, sdo shows term_off in hardware mode; interrupt has a pull-up
	assign sdo_wire = serial_out_pin_oe_o ? serial_out_pin_o :
		(host_mode_i == host_port_pkg::MODE_HW ? term_off : ~serial_out_pin_o);
	assign data_wire = data_pin_oe_o ? data_pin_o : (host_oe ? host_d : ~data_pin_o);
	assign irq_wire = irq_out_n_oe_o ? irq_out_n_o : 1'b1;

	host_port #(.ACK_CYCLES(4'h2), .ADDR_W(6)) u_dut (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.host_mode_i(host_mode_i), .strobe_style_i(strobe_style_i), .irq_event_i(irq_event_i),
		.serial_clk_pin_i(sclk), .serial_in_pin_i(serial_in_pin), .chip_select_n_i(cs_n),
		.rd_rw_pin_i(rd_rw), .wr_ds_pin_i(wr_ds), .ale_pin_i(ale),
		.output_edge_select_i(edge_sel), .addr_pin_i(addr), .data_pin_i(data_wire),
		.data_pin_o(data_pin_o), .data_pin_oe_o(data_pin_oe_o), .serial_out_pin_i(sdo_wire),
		.serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe_o(serial_out_pin_oe_o),
		.irq_out_n_o(irq_out_n_o), .irq_out_n_oe_o(irq_out_n_oe_o),
		.loopback_select_hi_i(lp_hi), .loopback_select_lo_i(lp_lo),
		.rx_termination_off_o(rx_termination_off_o), .loopback_mode_o(loopback_mode_o));

	host_cpu_model u_host (
		.sclk_o(sclk), .sdi_o(serial_in_pin), .cs_n_o(cs_n), .rd_rw_o(rd_rw), .wr_ds_o(wr_ds),
		.ale_o(ale), .edge_o(edge_sel), .addr_o(addr), .data_o(host_d), .data_oe_o(host_oe),
		.sdo_wire_i(sdo_wire), .sdo_oe_i(serial_out_pin_oe_o), .data_wire_i(data_wire));

	task automatic av_acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !wr;
		avs_write_i <= wr;
		do begin
			@(posedge core_clk_i);
		end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic do_reset(input logic [1:0] m, input logic s);
		@(posedge core_clk_i);
		rst_b_i <= 1'b0;
		host_mode_i <= m;
		strobe_style_i <= s;
		repeat (10) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
	endtask

	// an all-zero pulse doubles as a settle delay for the registered interrupt pin
	task automatic pulse(input logic [7:0] v);
		@(posedge core_clk_i);
		irq_event_i <= v;
		@(posedge core_clk_i);
		irq_event_i <= 8'h00;
		repeat (4) @(posedge core_clk_i);
	endtask

	function automatic logic [15:0] exp_lb(logic [7:0] hi, logic [7:0] lo);
		exp_lb = 16'h0000;
		for (int c = 0; c < 8; c++) begin
			exp_lb[2*c +: 2] = lo[c] ? host_port_pkg::LOOP_REMOTE :
				(hi[c] ? host_port_pkg::LOOP_ANALOG : host_port_pkg::LOOP_NONE);
		end
	endfunction

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		fail_count++;
		finish_test();
	end

	initial begin
		do_reset(host_port_pkg::MODE_SERIAL, 1'b0);
		av_acc(1'b0, host_port_pkg::CTRL_OFS, 32'h0, rd);
		`CHK("ctrl_drive_hi", host_port_pkg::CTRL_DRV_HI_RST, rd[0])
		av_acc(1'b0, host_port_pkg::IRQ_EN_OFS, 32'h0, rd);
		`CHK("irq_en_rst", host_port_pkg::IRQ_EN_RST, rd[7:0])
		av_acc(1'b0, host_port_pkg::IRQ_STAT_OFS, 32'h0, rd);
		`CHK("irq_stat_rst", host_port_pkg::IRQ_STAT_RST, rd[7:0])
		av_acc(1'b0, 4'h2, 32'h0, rd);
		`CHK("unmapped", 32'h0, rd)
		`CHK("irq_oe_rst", 1'b0, irq_out_n_oe_o)
		av_acc(1'b1, host_port_pkg::IRQ_EN_OFS, 32'h01, rd);
		pulse(8'h02);
		`CHK("irq_masked", 1'b1, irq_wire)
		pulse(8'h01);
		`CHK("irq_low", 1'b0, irq_wire)
		av_acc(1'b1, host_port_pkg::IRQ_STAT_OFS, 32'hFF, rd);
		pulse(8'h00);
		`CHK("irq_float", 1'b0, irq_out_n_oe_o)
		av_acc(1'b1, host_port_pkg::CTRL_OFS, 32'h01, rd);
		pulse(8'h00);
		`CHK("irq_drive_hi", 2'b11, {irq_out_n_oe_o, irq_out_n_o})
		av_acc(1'b1, host_port_pkg::IRQ_EN_OFS, 32'hFF, rd);
		av_acc(1'b1, host_port_pkg::CTRL_OFS, 32'h02, rd);
		av_acc(1'b0, host_port_pkg::IRQ_EN_OFS, 32'h0, rd);
		`CHK("irq_en_swrst", 8'h00, rd[7:0])
		pulse(8'h01);
		`CHK("irq_after_swrst", 1'b1, irq_wire)
		// write in one bit order, read back in the other, under both edge selects
		for (int k = 0; k < 4; k++) begin
			u_host.ser_xfer(1'b0, k[0], k[1], 6'h3C + k[5:0], 8'hA5 ^ k[7:0], rx, bad);
			`CHK("sdo_oe_write", 1'b0, bad)
			u_host.ser_xfer(1'b1, ~k[0], k[1], 6'h3C + k[5:0], 8'h00, rx, bad);
			`CHK("sdo_oe_cmd", 1'b0, bad)
			`CHK("ser_read", 8'hA5 ^ k[7:0], rx)
		end
		for (int i = 0; i < 3; i++) begin
			do_reset(i == 2 ? host_port_pkg::MODE_PAR_MUX : host_port_pkg::MODE_PAR_NONMUX, i == 1);
			u_host.par_cycle(1'b0, i == 1, i == 2, 6'h2A, 8'h5A + i[7:0], rx, ok);
			`CHK("par_wr_hs", 1'b1, ok)
			u_host.par_cycle(1'b1, i == 1, i == 2, 6'h2A, 8'h00, rx, ok);
			`CHK("par_rd_hs", 1'b1, ok)
			`CHK("par_rd", 8'h5A + i[7:0], rx)
		end
		do_reset(host_port_pkg::MODE_HW, 1'b0);
		for (int p = 0; p < 2; p++) begin
			@(posedge core_clk_i);
			lp_lo <= p ? 8'h00 : 8'h09;
			lp_hi <= p ? 8'hFF : 8'h0A;
			term_off <= !p;
			for (int w = 0; w < 30 && {rx_termination_off_o, loopback_mode_o} !==
				{logic'(!p), exp_lb(lp_hi, lp_lo)}; w++) @(posedge core_clk_i);
			`CHK("loopback", exp_lb(lp_hi, lp_lo), loopback_mode_o)
			`CHK("term_off", logic'(!p), rx_termination_off_o)
			av_acc(1'b0, host_port_pkg::STATUS_OFS, 32'h0, rd);
			`CHK("status_hw", {logic'(!p), exp_lb(lp_hi, lp_lo)}, rd[16:0])
		end
		`CHK("sdo_oe_hw", 1'b0, serial_out_pin_oe_o)
		finish_test();
	end
endmodule
`default_nettype wire
